// ### mesr_pkg.sv
// shared constants for the per-port mac event status registers
// assumes a 16-bit cpu port with byte addresses; 32-bit registers span two words
`default_nettype none

package mesr_pkg;

    // =====================================================================
    // register map (byte addresses, 16-bit words)
    localparam logic [7:0]  EVT_STATUS_ADDR = 8'h08;
    localparam logic [7:0]  WRAP_LO_ADDR    = 8'h0a;
    localparam logic [7:0]  WRAP_HI_ADDR    = 8'h0c;

    // =====================================================================
    // event status field positions
    localparam int          PAUSE_BIT       = 15;
    localparam int          MEDIA_BIT       = 13;
    localparam int          OVERLONG_BIT    = 12;
    localparam int          RUNT_BIT        = 11;
    localparam int          CRC_BIT         = 9;
    localparam int          FULL_BIT        = 8;
    localparam int          COUNT_LSB       = 6;
    localparam int          UNF_BIT         = 0;
    localparam logic [15:0] EVT_FLAG_MASK   = 16'hbb01;
    localparam logic [15:0] EVT_RESET       = 16'h0000;
    localparam logic [1:0]  COUNT_MAX       = 2'h2;
    localparam logic [15:0] RUNT_LEN        = 16'h0040;

    // =====================================================================
    // transmit counter wrap status
    localparam logic [31:0] WRAP_MASK       = 32'h000f_fe07;
    localparam logic [31:0] WRAP_RESET      = 32'h0000_0000;

endpackage : mesr_pkg

`default_nettype wire

// ### mesr_wrap_if.sv
// carrier between the status core and the transmit wrap register
// assumes both ends sit on the same clock
`default_nettype none

interface mesr_wrap_if;
    logic [19:0] wrap_pulse;
    logic        clear;
    logic [31:0] status;
    logic        pending;

    modport regs (input wrap_pulse, input clear, output status, output pending);
    modport core (output wrap_pulse, output clear, input status, input pending);
endinterface : mesr_wrap_if

`default_nettype wire

// ### mesr_wrap_regs.sv
// transmit counter wrap status register, cleared as a whole by the core
// assumes wrap pulses are one cycle per counter rollover, same clock
`default_nettype none

module mesr_wrap_regs
    import mesr_pkg::*;
(
    input  wire logic   ref_clk,
    input  wire logic   reset_n,
    mesr_wrap_if.regs   wrap
);
    import mesr_pkg::*;

    typedef struct packed {
        logic [31:0] flags;
    } mesr_wrap_state_t;

    mesr_wrap_state_t st;
    mesr_wrap_state_t next_st;
    logic [31:0]      set_vec;

    // =====================================================================
    // flags
    // unused rollover lines are masked so reserved bits can never rise
    assign set_vec = {12'h000, wrap.wrap_pulse} & WRAP_MASK; // R16 R19

    always_comb begin
        next_st = st;
        // a rollover in the clearing cycle survives the clear
        next_st.flags = (wrap.clear ? WRAP_RESET : st.flags) | set_vec; // R14 R15 R20
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wrap.status  = st.flags;
    assign wrap.pending = |st.flags; // R15

    // =====================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_wrap_set;
        (set_vec != 32'h0) |=> ((wrap.status & $past(set_vec)) == $past(set_vec));
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set"); // R14

    property p_wrap_clear;
        wrap.clear && (set_vec == 32'h0) |=> (wrap.status == 32'h0) && !wrap.pending;
    endproperty
    a_wrap_clear: assert property (p_wrap_clear) else $error("wrap clear failed"); // R15

    property p_wrap_reserved;
        (wrap.status & ~WRAP_MASK) == 32'h0;
    endproperty
    a_wrap_reserved: assert property (p_wrap_reserved) else $error("reserved wrap bit set"); // R19

    c_wrap_clear_race: cover property (wrap.clear && (set_vec != 32'h0));

endmodule : mesr_wrap_regs

`default_nettype wire

// ### mesr_core.sv
// per-port transmit/receive event status and transmit wrap status registers
// assumes mac paths, error mode bits and cpu strobes all come from ref_clk logic
//
// What this block does
// R1: reading event status clears all flags; the frame count survives the read.
// R2: underflow flag sets only when stop-on-underflow is configured.
// R3: receive error flags set only if their pass bit is set.
// R4: frame with any unpassed event sets no flag at all.
// R5: in append mode, frame status is written after the frame data.
// R6: bit 15 marks a received pause frame.
// R7: bit 13 marks symbol error in pcs mode or gmii error otherwise.
// R8: bit 12 marks a frame longer than the maximum frame length.
// R9: bit 11 marks a frame shorter than 64 bytes.
// R10: bit 9 marks a frame with bad crc.
// R11: bit 8 marks receive fifo running full during a frame.
// R12: bits 7:6 count frames in transmit fifo, at most two.
// R13: bit 0 marks transmit fifo empty while transmitter needs data.
// R14: a wrapping transmit counter sets its wrap flag.
// R15: reading the wrap register clears it and withdraws its pending signal.
// R16: wrap bits 19..16, 15..9 size bins, 2..0 cast types.
// R17: pass controls are pause, media error, overlong, runt, crc and fifo full frames.
// R18: a frame with an unpassed event is dropped from the receive fifo.
// R19: reserved bits read zero; both registers reset to zero.
// R20: an event in the clearing cycle survives the clear.
`default_nettype none

module mesr_core
    import mesr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // cpu register port
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_addr,
    output logic      [15:0] cpu_rdata,
    output logic             cpu_rvalid,
    // error mode bits
    input  wire logic        stop_on_underflow,
    input  wire logic        pass_pause_frames,
    input  wire logic        pass_media_error_frames,
    input  wire logic        pass_overlong_frames,
    input  wire logic        pass_runt_frames,
    input  wire logic        pass_crc_frames,
    input  wire logic        pass_fifo_full_frames,
    input  wire logic        pcs_coding_mode,
    input  wire logic        status_append_mode,
    input  wire logic [15:0] max_frame_length,
    // receive path, per-frame summary at frame end
    input  wire logic        rx_frame_end,
    input  wire logic [15:0] rx_frame_len,
    input  wire logic        rx_pause,
    input  wire logic        rx_symbol_err,
    input  wire logic        rx_gmii_err,
    input  wire logic        rx_crc_err,
    input  wire logic        rx_fifo_full,
    output logic             rx_frame_drop,
    output logic             rx_status_wr,
    output logic      [15:0] rx_status_word,
    // transmit path
    input  wire logic        tx_frame_load,
    input  wire logic        tx_frame_done,
    input  wire logic        tx_underflow,
    input  wire logic [19:0] tx_counter_wrap,
    output logic      [1:0]  tx_fifo_frame_count,
    output logic             tx_wrap_pending
);
    import mesr_pkg::*;

    typedef struct packed {
        logic [15:0] evt_flags;
        logic [1:0]  frame_count;
        logic [15:0] rdata;
        logic        rvalid;
        logic [15:0] wrap_hi_snap;
        logic        status_wr;
        logic [15:0] status_word;
        logic        frame_drop;
    } mesr_core_state_t;

    mesr_core_state_t st;
    mesr_core_state_t next_st;

    mesr_wrap_if wrap ();

    logic [15:0] rx_events;
    logic [15:0] pass_vec;
    logic        blocked;
    logic        accept;
    logic [15:0] set_vec;
    logic        rd_evt;
    logic        rd_lo;
    logic        rd_hi;
    logic [15:0] evt_view;
    logic        media_err;

    // =====================================================================
    // receive event classification
    always_comb begin
        media_err = pcs_coding_mode ? rx_symbol_err : rx_gmii_err; // R7
        rx_events               = 16'h0000;
        rx_events[PAUSE_BIT]    = rx_pause; // R6
        rx_events[MEDIA_BIT]    = media_err; // R7
        rx_events[OVERLONG_BIT] = rx_frame_len > max_frame_length; // R8
        rx_events[RUNT_BIT]     = rx_frame_len < RUNT_LEN; // R9
        rx_events[CRC_BIT]      = rx_crc_err; // R10
        rx_events[FULL_BIT]     = rx_fifo_full; // R11
        pass_vec                = 16'h0000;
        pass_vec[PAUSE_BIT]     = pass_pause_frames; // R17
        pass_vec[MEDIA_BIT]     = pass_media_error_frames; // R17
        pass_vec[OVERLONG_BIT]  = pass_overlong_frames; // R17
        pass_vec[RUNT_BIT]      = pass_runt_frames; // R17
        pass_vec[CRC_BIT]       = pass_crc_frames;
        pass_vec[FULL_BIT]      = pass_fifo_full_frames;
    end

    // one unpassed event blocks every flag of the frame, not only its own
    assign blocked = |(rx_events & ~pass_vec); // R3 R4
    assign accept  = rx_frame_end && !blocked;

    always_comb begin
        set_vec = accept ? rx_events : 16'h0000; // R3 R4
        set_vec[UNF_BIT] = tx_underflow && stop_on_underflow; // R2 R13
    end

    // =====================================================================
    // register decode
    assign rd_evt   = cpu_rd && (cpu_addr == EVT_STATUS_ADDR);
    assign rd_lo    = cpu_rd && (cpu_addr == WRAP_LO_ADDR);
    assign rd_hi    = cpu_rd && (cpu_addr == WRAP_HI_ADDR);
    assign evt_view = (st.evt_flags & EVT_FLAG_MASK)
                    | {8'h00, st.frame_count, 6'h00}; // R19

    assign wrap.wrap_pulse = tx_counter_wrap;
    // the low word read clears the whole register; the high half is kept in a snapshot
    assign wrap.clear      = rd_lo; // R15

    // =====================================================================
    // next state
    always_comb begin
        next_st = st;
        // flags raised in the read cycle stay for the next read
        next_st.evt_flags = ((rd_evt ? EVT_RESET : st.evt_flags) | set_vec)
                          & EVT_FLAG_MASK; // R1 R20

        // frame count is untouched by the read
        // saturation is judged per direction, so a load and a transmit together cancel
        unique case ({tx_frame_load, tx_frame_done})
            2'b10: begin
                if (st.frame_count < COUNT_MAX) begin
                    next_st.frame_count = st.frame_count + 2'h1; // R12
                end
            end
            2'b01: begin
                if (st.frame_count != 2'h0) begin
                    next_st.frame_count = st.frame_count - 2'h1; // R12
                end
            end
            default: begin
                next_st.frame_count = st.frame_count; // R12
            end
        endcase

        next_st.rvalid = cpu_rd;
        next_st.rdata  = 16'h0000;
        if (rd_evt) begin
            next_st.rdata = evt_view; // R1
        end else if (rd_lo) begin
            next_st.rdata        = wrap.status[15:0];
            next_st.wrap_hi_snap = wrap.status[31:16];
        end else if (rd_hi) begin
            next_st.rdata = st.wrap_hi_snap;
        end

        // status word follows the last data word of an accepted frame
        next_st.status_wr   = accept && status_append_mode; // R5
        next_st.status_word = accept ? rx_events : st.status_word; // R5
        next_st.frame_drop  = rx_frame_end && blocked; // R18
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    mesr_wrap_regs u_wrap (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .wrap    (wrap)
    );

    assign cpu_rdata           = st.rdata;
    assign cpu_rvalid          = st.rvalid;
    assign rx_frame_drop       = st.frame_drop;
    assign rx_status_wr        = st.status_wr;
    assign rx_status_word      = st.status_word;
    assign tx_fifo_frame_count = st.frame_count;
    assign tx_wrap_pending     = wrap.pending;

    // =====================================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_evt_clear;
        rd_evt && (set_vec == 16'h0000) |=> (st.evt_flags == 16'h0000);
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("read did not clear flags"); // R1

    property p_count_keep;
        rd_evt && !tx_frame_load && !tx_frame_done |=> $stable(tx_fifo_frame_count);
    endproperty
    a_count_keep: assert property (p_count_keep) else $error("read changed frame count"); // R1

    property p_read_data;
        rd_evt |=> cpu_rvalid && (cpu_rdata == $past(evt_view));
    endproperty
    a_read_data: assert property (p_read_data) else $error("event status read wrong"); // R1

    property p_unf_gate;
        tx_underflow && !stop_on_underflow && !st.evt_flags[UNF_BIT]
            |=> !st.evt_flags[UNF_BIT];
    endproperty
    a_unf_gate: assert property (p_unf_gate) else $error("underflow set without stop"); // R2

    property p_unf_set;
        tx_underflow && stop_on_underflow |=> st.evt_flags[UNF_BIT];
    endproperty
    a_unf_set: assert property (p_unf_set) else $error("underflow flag lost"); // R20

    property p_blocked;
        rx_frame_end && blocked && !rd_evt && (st.evt_flags[15:8] == 8'h00)
            |=> rx_frame_drop && !rx_status_wr && (st.evt_flags[15:8] == 8'h00);
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked frame set flags"); // R4

    property p_runt;
        accept && (rx_frame_len < RUNT_LEN) |=> st.evt_flags[RUNT_BIT];
    endproperty
    a_runt: assert property (p_runt) else $error("runt flag missing"); // R9

    property p_pause;
        accept && rx_pause |=> st.evt_flags[PAUSE_BIT];
    endproperty
    a_pause: assert property (p_pause) else $error("pause flag missing"); // R6

    property p_append;
        accept && status_append_mode
            |=> rx_status_wr && (rx_status_word == $past(rx_events))
                ##1 (!rx_status_wr || $past(accept));
    endproperty
    a_append: assert property (p_append) else $error("status append wrong"); // R5

    property p_count_max;
        tx_fifo_frame_count <= COUNT_MAX;
    endproperty
    a_count_max: assert property (p_count_max) else $error("frame count above two"); // R12

    property p_count_both;
        tx_frame_load && tx_frame_done |=> $stable(tx_fifo_frame_count);
    endproperty
    a_count_both: assert property (p_count_both) else $error("load with done moved count"); // R12

    property p_count_up;
        tx_frame_load && !tx_frame_done && (tx_fifo_frame_count != COUNT_MAX)
            |=> (tx_fifo_frame_count == $past(tx_fifo_frame_count) + 2'h1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("frame load not counted"); // R12

    property p_media;
        accept && (pcs_coding_mode ? rx_symbol_err : rx_gmii_err) |=> st.evt_flags[MEDIA_BIT];
    endproperty
    a_media: assert property (p_media) else $error("media error flag missing"); // R7

    property p_overlong;
        accept && (rx_frame_len > max_frame_length) |=> st.evt_flags[OVERLONG_BIT];
    endproperty
    a_overlong: assert property (p_overlong) else $error("overlong flag missing"); // R8

    property p_crc;
        accept && rx_crc_err |=> st.evt_flags[CRC_BIT];
    endproperty
    a_crc: assert property (p_crc) else $error("crc flag missing"); // R10

    property p_full;
        accept && rx_fifo_full |=> st.evt_flags[FULL_BIT];
    endproperty
    a_full: assert property (p_full) else $error("fifo full flag missing"); // R11

    property p_pass_gate;
        rx_frame_end && rx_pause && !pass_pause_frames && !st.evt_flags[PAUSE_BIT]
            |=> !st.evt_flags[PAUSE_BIT];
    endproperty
    a_pass_gate: assert property (p_pass_gate) else $error("unpassed event flagged"); // R3

    property p_status_hold;
        !accept |=> $stable(rx_status_word);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status word changed"); // R5

    c_read_race: cover property (rd_evt && (set_vec != 16'h0000));
    c_drop:      cover property (rx_frame_end && blocked);
    c_append:    cover property (rx_status_wr);
    c_count_two: cover property (tx_fifo_frame_count == COUNT_MAX);

endmodule : mesr_core

`default_nettype wire

// ### mesr_core_test.sv
// self-checking bench for the per-port mac event status registers
// assumes mesr_core stands alone; every input is driven on the falling edge of ref_clk
`default_nettype none

module mesr_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mesr_pkg::*;

    // ==========================================================================
    // signals
    logic        ref_clk, reset_n, cpu_rd, stop_on_underflow, pcs_coding_mode;
    logic        status_append_mode, pass_pause_frames, pass_media_error_frames;
    logic        pass_overlong_frames, pass_runt_frames, pass_crc_frames, pass_fifo_full_frames;
    logic        rx_frame_end, rx_pause, rx_symbol_err, rx_gmii_err, rx_crc_err, rx_fifo_full;
    logic        tx_frame_load, tx_frame_done, tx_underflow;
    logic        cpu_rvalid, rx_frame_drop, rx_status_wr, tx_wrap_pending;
    logic [7:0]  cpu_addr;
    logic [15:0] cpu_rdata, max_frame_length, rx_frame_len, rx_status_word;
    logic [19:0] tx_counter_wrap;
    logic [1:0]  tx_fifo_frame_count;
    int          n_errors;
    int          compares;

    // receive cases: length, events {pause, symbol, gmii, crc, full}, pcs mode, flags
    logic [15:0] t_len  [10] = '{16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064,
                                 16'h05ef, 16'h0028, 16'h0064, 16'h05ee, 16'h0040};
    logic [4:0]  t_ev   [10] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01,
                                 5'h00, 5'h00, 5'h04, 5'h00, 5'h00};
    logic [9:0]  t_pcs       = 10'h082;
    logic [15:0] t_word [10] = '{16'h8000, 16'h2000, 16'h2000, 16'h0200, 16'h0100,
                                 16'h1000, 16'h0800, 16'h0000, 16'h0000, 16'h0000};

    mesr_core i_dut (
        .ref_clk, .reset_n, .cpu_rd, .cpu_addr, .cpu_rdata, .cpu_rvalid,
        .stop_on_underflow, .pass_pause_frames, .pass_media_error_frames,
        .pass_overlong_frames, .pass_runt_frames, .pass_crc_frames, .pass_fifo_full_frames,
        .pcs_coding_mode, .status_append_mode, .max_frame_length,
        .rx_frame_end, .rx_frame_len, .rx_pause, .rx_symbol_err, .rx_gmii_err,
        .rx_crc_err, .rx_fifo_full, .rx_frame_drop, .rx_status_wr, .rx_status_word,
        .tx_frame_load, .tx_frame_done, .tx_underflow, .tx_counter_wrap,
        .tx_fifo_frame_count, .tx_wrap_pending
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // ends with an idle edge so the strobe is never lowered and raised in one step
    task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
        cpu_rd = 1'b1;
        cpu_addr = addr;
        @(negedge ref_clk);
        cpu_rd = 1'b0;
        chk(cpu_rvalid, 1'b1);
        chk(cpu_rdata, exp);
        @(negedge ref_clk);
    endtask : rd

    task automatic set_pass(input logic [15:0] m);
        pass_pause_frames = m[PAUSE_BIT];
        pass_media_error_frames = m[MEDIA_BIT];
        pass_overlong_frames = m[OVERLONG_BIT];
        pass_runt_frames = m[RUNT_BIT];
        pass_crc_frames = m[CRC_BIT];
        pass_fifo_full_frames = m[FULL_BIT];
    endtask : set_pass

    task automatic frame(input logic [15:0] len, input logic [4:0] ev, input logic drop,
                         input logic [15:0] word);
        rx_frame_len = len;
        {rx_pause, rx_symbol_err, rx_gmii_err, rx_crc_err, rx_fifo_full} = ev;
        rx_frame_end = 1'b1;
        @(negedge ref_clk);
        rx_frame_end = 1'b0;
        // summaries are only valid with the end strobe, so show garbage afterwards
        {rx_pause, rx_symbol_err, rx_gmii_err, rx_crc_err, rx_fifo_full} = ~ev;
        chk(rx_frame_drop, drop);
        chk(rx_status_wr, status_append_mode & ~drop);
        if (!drop && status_append_mode) chk(rx_status_word, word);
        @(negedge ref_clk);
    endtask : frame

    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================================
    // watchdog: the sequence needs under two hundred cycles
    initial begin
        #100us;
        n_errors++;
        wrap_up();
    end

    // ==========================================================================
    // main sequence
    initial begin
        n_errors = 0;
        compares = 0;
        reset_n = 1'b0;
        {cpu_rd, stop_on_underflow, pcs_coding_mode, rx_frame_end} = 4'h0;
        {tx_frame_load, tx_frame_done, tx_underflow} = 3'h0;
        cpu_addr = 8'h00;
        status_append_mode = 1'b1;
        max_frame_length = 16'h05ee;
        rx_frame_len = 16'h0000;
        {rx_pause, rx_symbol_err, rx_gmii_err, rx_crc_err, rx_fifo_full} = 5'h00;
        tx_counter_wrap = 20'h0_0000;
        set_pass(16'hffff);
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        chk(tx_fifo_frame_count, 2'h0);
        rd(EVT_STATUS_ADDR, 16'h0000);
        rd(WRAP_LO_ADDR, 16'h0000);
        rd(WRAP_HI_ADDR, 16'h0000);
        rd(8'h02, 16'h0000);
        rd(8'h0e, 16'h0000);
        // each event passed, then the same event refused
        for (int i = 0; i < 10; i++) begin
            pcs_coding_mode = t_pcs[i];
            set_pass(16'hffff);
            frame(t_len[i], t_ev[i], 1'b0, t_word[i]);
            rd(EVT_STATUS_ADDR, t_word[i]);
            if (t_word[i] != 16'h0000) begin
                set_pass(~t_word[i]);
                frame(t_len[i], t_ev[i], 1'b1, 16'h0000);
                rd(EVT_STATUS_ADDR, 16'h0000);
            end
        end
        // two events, only one of them passed
        set_pass(~16'h0200);
        frame(16'h0028, 5'h02, 1'b1, 16'h0000);
        rd(EVT_STATUS_ADDR, 16'h0000);
        set_pass(16'hffff);
        frame(16'h0028, 5'h02, 1'b0, 16'h0a00);
        rd(EVT_STATUS_ADDR, 16'h0a00);
        rd(EVT_STATUS_ADDR, 16'h0000);
        status_append_mode = 1'b0;
        frame(16'h0028, 5'h00, 1'b0, 16'h0800);
        rd(EVT_STATUS_ADDR, 16'h0800);
        status_append_mode = 1'b1;
        // transmit frame count: three loads back to back saturate at two
        tx_frame_load = 1'b1;
        repeat (3) @(negedge ref_clk);
        tx_frame_load = 1'b0;
        chk(tx_fifo_frame_count, 2'h2);
        rd(EVT_STATUS_ADDR, 16'h0080);
        rd(EVT_STATUS_ADDR, 16'h0080);
        tx_frame_load = 1'b1;
        tx_frame_done = 1'b1;
        @(negedge ref_clk);
        tx_frame_load = 1'b0;
        chk(tx_fifo_frame_count, 2'h2);
        for (int c = 1; c >= -1; c--) begin
            @(negedge ref_clk);
            chk(tx_fifo_frame_count, (c < 0) ? 2'h0 : 2'(c));
        end
        tx_frame_done = 1'b0;
        // underflow only flagged with stop-on-underflow
        for (int j = 0; j < 2; j++) begin
            stop_on_underflow = j[0];
            tx_underflow = 1'b1;
            @(negedge ref_clk);
            tx_underflow = 1'b0;
            @(negedge ref_clk);
            rd(EVT_STATUS_ADDR, 16'(j));
        end
        // counter wraps, reserved pulses included
        tx_counter_wrap = 20'hf_ffff;
        @(negedge ref_clk);
        tx_counter_wrap = 20'h0_0000;
        chk(tx_wrap_pending, 1'b1);
        @(negedge ref_clk);
        rd(WRAP_HI_ADDR, 16'h0000);
        rd(WRAP_LO_ADDR, 16'hfe07);
        chk(tx_wrap_pending, 1'b0);
        rd(WRAP_HI_ADDR, 16'h000f);
        rd(WRAP_LO_ADDR, 16'h0000);
        tx_counter_wrap = 20'h0_0200;
        @(negedge ref_clk);
        tx_counter_wrap = 20'h0_0000;
        @(negedge ref_clk);
        rd(WRAP_LO_ADDR, 16'h0200);
        // event and clearing read in the same cycle
        for (int k = 0; k < 2; k++) begin
            rx_frame_len = 16'h0028;
            {rx_pause, rx_symbol_err, rx_gmii_err, rx_crc_err, rx_fifo_full} = 5'h00;
            rx_frame_end = 1'b1;
            tx_counter_wrap = 20'h0_0001;
            cpu_rd = 1'b1;
            cpu_addr = (k == 0) ? EVT_STATUS_ADDR : WRAP_LO_ADDR;
            @(negedge ref_clk);
            {rx_frame_end, cpu_rd} = 2'h0;
            tx_counter_wrap = 20'h0_0000;
            @(negedge ref_clk);
            rd(EVT_STATUS_ADDR, 16'h0800);
            rd(WRAP_LO_ADDR, 16'h0001);
        end
        wrap_up();
    end

endmodule : mesr_core_test

`default_nettype wire
